// ==== design/tbcp_parser.sv ====
// Design decisions made here: the placing of the registers and the strobed register port.
`default_nettype none
// Functional notes
// - Each buffer opens with two command words, first then second, before payload.
// - Second command word must match across a frame, checksum bit excluded; else error.
// - Declared frame length compared at closing segment with the sum of the buffer byte counts; mismatch is error.
// - First word bits 17:16 give payload start offset, zero to three bytes.
// - First word bit 13 marks the opening segment of a frame.
// - First word bit 12 marks the closing segment of a frame.
// - First word bits 10:0 give payload byte count of this buffer.
// - Byte count plus offset locate trailing filler bytes, which are forwarded with byte enables low.
// - Frame length is second word bits 10:0, excluding offset and padding.
// - Payload starts in third word; offset zero selects lane D[7:0] first.
// - Unused lanes of the final word are still forwarded in the beat data, with their byte enables low.

////////////////////////////////////////////////////////////////////////////////
module tbcp_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	wire do_wr = i_in_valid && o_in_ready;
	wire do_rd = o_out_valid && i_out_ready;
	// Flags come from flops so the beat side never sees a compare glitch
	logic in_ready_ff;
	logic out_valid_ff;
	wire [AW:0] nxt_count = count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	assign o_in_ready = in_ready_ff;
	assign o_out_valid = out_valid_ff;
	assign o_out_data = mem_ff[rd_ptr_ff];
	always_ff @(posedge i_mclk) begin
		if (do_wr) begin
			mem_ff[wr_ptr_ff] <= i_in_data;
		end
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_ff <= 1'b1;
			out_valid_ff <= 1'b0;
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= nxt_count;
			in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
			out_valid_ff <= (nxt_count != '0);
		end
	end
endmodule // tbcp_fifo

////////////////////////////////////////////////////////////////////////////////
module tbcp_parser
	import tbcp_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_word_valid,
	output logic o_word_ready,
	input wire logic [tbcp_pkg::WORD_W-1:0] i_word,
	output logic o_beat_valid,
	input wire logic i_beat_ready,
	output tbcp_pkg::tbcp_beat_type o_beat,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_transmit_error_flag
);
	import tbcp_pkg::*;

	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_COUNT = 4'h4;
	localparam logic [3:0] REG_CMDB = 4'h8;
	localparam int ERR_BIT = 0;
	localparam int STRICT_BIT = 1;

	typedef enum logic [3:0] {
		ST_CMD_A = 4'b0001,
		ST_CMD_B = 4'b0010,
		ST_DATA = 4'b0100,
		ST_SKIP = 4'b1000
	} tbcp_state_type;

	tbcp_state_type state_ff, nxt_state;
	tbcp_cmd_a_type cmd_a_ff;
	logic [31:0] cmd_b_ff;
	logic [31:0] ref_b_ff;
	logic in_frame_ff;
	logic [LEN_W-1:0] run_sum_ff;
	logic [LEN_W-1:0] remain_ff;
	logic first_beat_ff;
	logic err_ff;
	logic [31:0] rdata_ff;
	logic [15:0] frames_ff;
	logic fifo_in_ready;
	tbcp_beat_type beat_in;

	// Command A decode, reserved bits dropped
	tbcp_cmd_a_type dec_a;
	assign dec_a.start_offset = i_word[A_OFS_HI:A_OFS_LO];
	assign dec_a.frame_start = i_word[A_FIRST_BIT];
	assign dec_a.frame_end = i_word[A_LAST_BIT];
	assign dec_a.buf_size = i_word[LEN_HI:LEN_LO];

	wire take = i_word_valid && o_word_ready;
	wire [LEN_W-1:0] frame_len = i_word[LEN_HI:LEN_LO];
	// Lanes available in this word
	wire [1:0] lo_lane = first_beat_ff ? cmd_a_ff.start_offset : 2'h0;
	wire [2:0] avail = LANES - {1'b0, lo_lane};
	wire last_word = ({8'h00, avail} >= remain_ff);
	wire [2:0] used = last_word ? remain_ff[2:0] : avail;
	// One past the highest lane that carries payload in this word
	wire [2:0] hi_lane = 3'({1'b0, lo_lane} + used);
	logic [3:0] en_mask;
	for (genvar ln = 0; ln < 4; ln++) begin : g_lane
		assign en_mask[ln] = (3'(ln) >= {1'b0, lo_lane}) && (3'(ln) < hi_lane);
	end
	wire [LEN_W-1:0] remain_next = remain_ff - {8'h00, used};
	wire seg_last = cmd_a_ff.frame_end;
	wire b_mismatch = in_frame_ff && ((i_word & B_CMP_MASK) != (ref_b_ff & B_CMP_MASK));
	wire [LEN_W-1:0] new_sum = LEN_W'(run_sum_ff + cmd_a_ff.buf_size);
	wire len_bad = seg_last && (new_sum != frame_len);
	wire err_set = (state_ff == ST_CMD_B) && take && (b_mismatch || len_bad);
	wire clr_err = i_wr && (i_addr == REG_STATUS) && i_wdata[ERR_BIT];

	assign beat_in.data = i_word;
	assign beat_in.byte_en = en_mask;
	assign beat_in.first = first_beat_ff && cmd_a_ff.frame_start;
	assign beat_in.last = last_word && seg_last;

	// Stall payload words while the FIFO is full; command words are always taken
	assign o_word_ready = (state_ff == ST_DATA) ? fifo_in_ready : 1'b1;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_CMD_A: if (take) nxt_state = ST_CMD_B;
			ST_CMD_B: begin
				if (take) nxt_state = (cmd_a_ff.buf_size == LEN_ZERO) ? ST_CMD_A : ST_DATA;
			end
			ST_DATA: if (take && last_word) nxt_state = ST_CMD_A;
			ST_SKIP: nxt_state = ST_CMD_A;
			default: nxt_state = ST_CMD_A;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= ST_CMD_A;
			cmd_a_ff <= '0;
			cmd_b_ff <= '0;
			ref_b_ff <= '0;
			in_frame_ff <= 1'b0;
			run_sum_ff <= '0;
			remain_ff <= '0;
			first_beat_ff <= 1'b0;
			frames_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			if (take && state_ff == ST_CMD_A) begin
				cmd_a_ff <= dec_a;
				if (dec_a.frame_start) begin
					in_frame_ff <= 1'b0;
					run_sum_ff <= '0;
				end
			end
			if (take && state_ff == ST_CMD_B) begin
				cmd_b_ff <= i_word & B_USED_MASK;
				if (!in_frame_ff) ref_b_ff <= i_word;
				in_frame_ff <= !seg_last;
				run_sum_ff <= seg_last ? LEN_ZERO : new_sum;
				remain_ff <= cmd_a_ff.buf_size;
				first_beat_ff <= 1'b1;
				if (seg_last) frames_ff <= frames_ff + 16'h0001;
			end
			if (take && state_ff == ST_DATA) begin
				remain_ff <= remain_next;
				first_beat_ff <= 1'b0;
			end
		end
	end

	// Set beats clear in the same cycle
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			err_ff <= 1'b0;
		end else if (err_set) begin
			err_ff <= 1'b1;
		end else if (clr_err) begin
			err_ff <= 1'b0;
		end
	end

	wire [31:0] rd_mux = (i_addr == REG_STATUS) ? {29'h0, in_frame_ff, 1'b0, err_ff} :
		(i_addr == REG_COUNT) ? {frames_ff, 5'h00, run_sum_ff} :
		(i_addr == REG_CMDB) ? cmd_b_ff : 32'h0000_0000;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_transmit_error_flag = err_ff;

	tbcp_fifo #(
		.WIDTH($bits(tbcp_beat_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_in_valid(take && state_ff == ST_DATA),
		.o_in_ready(fifo_in_ready),
		.i_in_data(beat_in),
		.o_out_valid(o_beat_valid),
		.i_out_ready(i_beat_ready),
		.o_out_data(o_beat)
	);
endmodule // tbcp_parser
`default_nettype wire

// ==== design/tbcp_pkg.sv ====
`default_nettype none
package tbcp_pkg;
	localparam int WORD_W = 32;
	localparam int LEN_W = 11;
	localparam int FIFO_DEPTH = 8;
	// First command word fields
	localparam int A_OFS_HI = 17;
	localparam int A_OFS_LO = 16;
	localparam int A_FIRST_BIT = 13;
	localparam int A_LAST_BIT = 12;
	localparam int LEN_HI = 10;
	localparam int LEN_LO = 0;
	// Second command word fields, then length and lane constants
	localparam int B_CKSUM_BIT = 14;
	localparam logic [31:0] B_CMP_MASK = 32'hFFFF_BFFF;
	localparam logic [31:0] B_USED_MASK = 32'h0000_37FF;
	localparam logic [10:0] LEN_ZERO = 11'h000;
	localparam logic [1:0] LANE_LAST = 2'h3;
	localparam logic [2:0] LANES = 3'h4;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] byte_en;
		logic first;
		logic last;
	} tbcp_beat_type;

	typedef struct packed {
		logic frame_start;
		logic frame_end;
		logic [1:0] start_offset;
		logic [10:0] buf_size;
	} tbcp_cmd_a_type;
endpackage
`default_nettype wire

// ==== bench/tbcp_parser_chk.sv ====
`default_nettype none
module tbcp_parser_chk
	import tbcp_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_word_valid,
	input wire logic o_word_ready,
	input wire logic [31:0] i_word,
	input wire logic o_beat_valid,
	input wire logic i_beat_ready,
	input wire tbcp_pkg::tbcp_beat_type o_beat,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_transmit_error_flag
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	wire logic take = i_word_valid && o_word_ready;
	wire logic rd0 = i_rd && i_addr == 4'h0;
	wire logic clr = i_wr && i_addr == 4'h0 && i_wdata[0];
	a_lane_run: assert property (o_beat_valid |-> o_beat.byte_en inside
		{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF}) else $error("lanes");
	a_beat_hold: assert property (o_beat_valid && !i_beat_ready |=>
		o_beat_valid && $stable(o_beat)) else $error("beat moved");
	a_ready_empty: assert property (!o_beat_valid |-> o_word_ready)
		else $error("ready low");
	a_err_sticky: assert property (o_transmit_error_flag && !clr |=>
		o_transmit_error_flag) else $error("error lost");
	a_err_clear: assert property (clr && !take |=> !o_transmit_error_flag)
		else $error("error kept");
	a_err_cause: assert property ($rose(o_transmit_error_flag) |-> $past(take))
		else $error("error uncaused");
	a_stat_err: assert property (rd0 |=> o_rdata[0] == $past(o_transmit_error_flag))
		else $error("status bit");
	a_stat_rsvd: assert property (rd0 |=> o_rdata[31:3] == 29'h0 && !o_rdata[1])
		else $error("status rsvd");
	c_first: cover property (o_beat_valid && o_beat.first && i_beat_ready);
	c_err: cover property ($rose(o_transmit_error_flag));
	c_full: cover property (i_word_valid && !o_word_ready);
endmodule // tbcp_parser_chk
bind tbcp_parser tbcp_parser_chk tbcp_parser_chk_i (.i_mclk, .i_rst, .i_word_valid,
	.o_word_ready, .i_word, .o_beat_valid, .i_beat_ready, .o_beat, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .o_transmit_error_flag);
`default_nettype wire

// ==== bench/tbcp_host_model.sv ====
`default_nettype none
module tbcp_host_model (
	input wire logic i_mclk,
	input wire logic i_rst,
	output logic o_valid,
	input wire logic i_ready,
	output logic [31:0] o_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] q[$];
	initial o_valid = 1'b0;
	initial o_word = 32'h0;
	// Idle bus alternates the last word with its inverse on every cycle
	always @(posedge i_mclk) begin
		if (o_valid && i_ready)
			void'(q.pop_front());
		o_valid <= !i_rst && q.size() != 0;
		o_word <= (q.size() != 0) ? q[0] : ~o_word;
	end
endmodule // tbcp_host_model
`default_nettype wire

// ==== bench/tbcp_parser_tb.sv ====
`default_nettype none
module tbcp_parser_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tbcp_pkg::*;
	logic i_mclk = 0, i_rst = 1, i_beat_ready = 1, i_wr = 0, i_rd = 0, seen;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0, i_word, o_rdata, d;
	logic i_word_valid, o_word_ready, o_beat_valid, o_transmit_error_flag;
	tbcp_beat_type o_beat, e, g, eq[$], gq[$];
	int err_total = 0, n_tests = 0;
	always #4 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (o_beat_valid && i_beat_ready) gq.push_back(o_beat);
	tbcp_parser tbcp_parser_i (.i_mclk, .i_rst, .i_word_valid, .o_word_ready, .i_word,
		.o_beat_valid, .i_beat_ready, .o_beat, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.o_transmit_error_flag);
	tbcp_host_model tbcp_host_model_i (.i_mclk, .i_rst, .o_valid(i_word_valid),
		.i_ready(o_word_ready), .o_word(i_word));
	////////////////////////////////////////
	task automatic chk(string s, logic [63:0] x, logic [63:0] y);
		n_tests++;
		if (x !== y) begin
			err_total++;
			$display("ERROR %s exp %h got %h", s, x, y);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic rd(logic [3:0] a);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 0;
		#1 d = o_rdata;
		@(posedge i_mclk);
	endtask
	// Reads status; a set error is cleared and read again
	task automatic err_is(logic x);
		rd(4'h0);
		chk("error", x, d[0]);
		if (x) begin
			i_wr <= 1;
			i_wdata <= 32'h1;
			@(posedge i_mclk);
			i_wr <= 0;
			rd(4'h0);
			chk("cleared", 0, d[0]);
		end
	endtask
	task automatic put(logic fs, logic ls, logic [1:0] off, int sz, logic [10:0] len,
		logic [31:0] bx);
		int n, lo, hi;
		n = (off + sz + 3) / 4;
		tbcp_host_model_i.q.push_back({14'h0, off, 2'h0, fs, ls, 1'b0, sz[10:0]});
		tbcp_host_model_i.q.push_back(bx | len);
		for (int k = 0; k < n; k++) begin
			lo = (k == 0) ? off : 0;
			hi = (k == n - 1) ? (off + sz - 1) % 4 : 3;
			e.data = 32'hC3A5_0F00 + k;
			e.byte_en = (4'hF << lo) & (4'hF >> (3 - hi));
			e.first = fs && k == 0;
			e.last = ls && k == n - 1;
			tbcp_host_model_i.q.push_back(e.data);
			eq.push_back(e);
		end
	endtask
	// Filler lanes carry no meaning, so only enabled lanes are compared
	task automatic settle();
		for (int c = 0; c < 300 && gq.size() < eq.size(); c++)
			@(posedge i_mclk);
		if (gq.size() != eq.size()) begin
			err_total++;
			conclude();
		end
		while (eq.size() > 0) begin
			e = eq.pop_front();
			g = gq.pop_front();
			for (int b = 0; b < 4; b++)
				if (!e.byte_en[b]) g.data[8*b+:8] = e.data[8*b+:8];
			chk("beat", e, g);
		end
		@(posedge i_mclk);
	endtask
	task automatic t_single();
		put(1, 1, 2'h1, 6, 11'h006, 32'h8000_0800);
		settle();
		err_is(0);
		rd(4'hC);
		chk("unmapped", 0, d);
	endtask
	task automatic t_split();
		put(1, 0, 2'h3, 4, 11'h009, 32'h0000_4000);
		put(0, 1, 2'h0, 5, 11'h009, 32'h0);
		settle();
		err_is(0);
		rd(4'h8);
		chk("cmd b", 32'h0000_0009, d);
		rd(4'h4);
		chk("count", 32'h0002_0000, d);
	endtask
	task automatic t_reset();
		put(1, 0, 2'h0, 4, 11'h008, 32'h0);
		settle();
		rd(4'h0);
		chk("in frame", 32'h0000_0004, d);
		i_rst <= 1;
		repeat (3) @(posedge i_mclk);
		i_rst <= 0;
		@(posedge i_mclk);
		rd(4'h4);
		chk("count reset", 0, d);
		rd(4'h0);
		chk("status reset", 0, d);
	endtask
	task automatic t_len_bad();
		put(1, 1, 2'h2, 4, 11'h005, 32'h0);
		settle();
		err_is(1);
	endtask
	task automatic t_b_diff();
		put(1, 0, 2'h0, 4, 11'h008, 32'h0);
		put(0, 1, 2'h0, 4, 11'h008, 32'h0000_2000);
		settle();
		err_is(1);
	endtask
	task automatic t_stall();
		i_beat_ready <= 0;
		put(1, 1, 2'h0, 40, 11'h028, 32'h0);
		seen = 0;
		repeat (30) @(posedge i_mclk) seen |= !o_word_ready;
		chk("refused", 1, seen);
		i_beat_ready <= 1;
		settle();
		chk("drained", 0, o_beat_valid);
		err_is(0);
	endtask
	initial begin
		repeat (10) @(posedge i_mclk);
		i_rst <= 0;
		@(posedge i_mclk);
		t_single();
		t_split();
		t_len_bad();
		t_b_diff();
		t_stall();
		t_reset();
		conclude();
	end
endmodule // tbcp_parser_tb
`default_nettype wire
